// *** hw/ddc_power_ctrl.sv ***
// Dual converter command decoder with per-channel power-down and wake-up timing.
// Assumes the three serial pins and the supply strap are asynchronous to mclk.
//
// Function
// - Power-down command with channel address powers down that channel or both.
// - Data field of a power-down frame is ignored.
// - Power-down leaves input and converter codes unchanged.
// - Powered-down channel output is high impedance with pull to ground.
// - Any command with an update wakes each channel it updates; CMD_WRITE_ALL updates both, whatever the address.
// - Channel wakes at the same moment its converter code is updated.
// - Waking one channel alone takes five microseconds to settle.
// - Both down shuts the bias; wake then takes 12 or 30 microseconds.
// - Four write and update codes; those with an update also wake.
// - While select is low, data is sampled on each rising serial clock.
// - Rising select ends the frame and executes the shifted command once at least 24 bits are in.
`timescale 1ns/1ps
module ddc_power_ctrl
	import ddc_pkg::*;
#(
	parameter int WAKE_BIAS3_CYCLES = WAKE_BIAS3_CYC
) (
	input  wire logic               mclk,
	input  wire logic               reset,
	input  wire logic               selectAndLoad,
	input  wire logic               serialClk,
	input  wire logic               serialIn,
	input  wire logic               supplyHigh,
	output ddc_chan_type [1:0]      chanStat,
	output logic                    biasOn
);
	// ----------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------
	// The synchronisers wake up at the pins' idle levels, so that no false frame opens after reset.
	localparam logic [3:0]   SYNC_IDLE = 4'h1;
	logic [3:0]              syncA_reg, syncA_next;
	logic [3:0]              syncB_reg, syncB_next;
	logic                    sckPrev_reg, sckPrev_next;
	logic                    selHigh, sckRise, sdiBit, supply5v;

	always_comb begin
		syncA_next   = {supplyHigh, serialIn, serialClk, selectAndLoad};
		syncB_next   = syncA_reg;
		sckPrev_next = syncB_reg[1];
	end

	assign selHigh  = syncB_reg[0];
	assign sckRise  = syncB_reg[1] & ~sckPrev_reg;
	assign sdiBit   = syncB_reg[2];
	assign supply5v = syncB_reg[3];

	// ----------------------------------------
	// Frame shifter
	// ----------------------------------------
	ddc_frame_type           frame_reg, frame_next;
	logic [SHIFT_W-1:0]      shift_reg, shift_next;
	logic [CNT_W-1:0]        cnt_reg, cnt_next;
	logic [3:0]              cmd, addr;

	assign cmd  = shift_reg[CMD_MSB:CMD_LSB];
	assign addr = shift_reg[ADDR_MSB:ADDR_LSB];

	always_comb begin
		frame_next = frame_reg;
		shift_next = shift_reg;
		cnt_next   = cnt_reg;
		case (frame_reg)
			FR_IDLE: begin
				if (!selHigh) begin
					frame_next = FR_SHIFT;
					cnt_next   = '0;
				end
			end
			FR_SHIFT: begin
				if (selHigh) begin
					// Frames shorter than 24 bits are dropped.
					frame_next = (cnt_reg >= CNT_W'(FRAME_BITS)) ? FR_EXEC : FR_IDLE;
				end else if (sckRise) begin
					shift_next = {shift_reg[SHIFT_W-2:0], sdiBit};
					if (cnt_reg < CNT_W'(SHIFT_W)) begin
						cnt_next = cnt_reg + CNT_W'(1);
					end
				end
			end
			FR_EXEC: begin
				frame_next = FR_IDLE;
			end
			default: begin
				frame_next = FR_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Channel state and wake timing
	// ----------------------------------------
	ddc_chan_type [1:0]      chan_reg, chan_next;
	logic [WAKE_W-1:0]       wake_reg [2];
	logic [WAKE_W-1:0]       wake_next [2];
	logic                    bias_reg, bias_next;
	logic [1:0]              upd, wr, pdn;
	logic                    bothDown;

	function automatic logic addrHit(input logic [3:0] a, input logic ch);
		addrHit = (a == ADDR_ALL) || (a == (ch ? ADDR_B : ADDR_A));
	endfunction

	assign bothDown = chan_reg[0].powerDown & chan_reg[1].powerDown;

	always_comb begin
		chan_next = chan_reg;
		for (int i = 0; i < 2; i++) begin
			wake_next[i] = wake_reg[i];
			upd[i] = 1'b0;
			wr[i]  = 1'b0;
			pdn[i] = 1'b0;
			if (frame_reg == FR_EXEC) begin
				wr[i]  = addrHit(addr, i[0]) &&
					(cmd == CMD_WRITE || cmd == CMD_WRITE_ALL || cmd == CMD_WRITE_UPD);
				upd[i] = (cmd == CMD_WRITE_ALL) ||
					(addrHit(addr, i[0]) && (cmd == CMD_UPDATE || cmd == CMD_WRITE_UPD));
				pdn[i] = addrHit(addr, i[0]) && (cmd == CMD_PDOWN);
			end
			if (wake_reg[i] != '0) begin
				wake_next[i] = wake_reg[i] - WAKE_W'(1);
				if (wake_reg[i] == WAKE_W'(1)) begin
					chan_next[i].settled = 1'b1;
				end
			end
			if (wr[i]) begin
				chan_next[i].inputCode = shift_reg[DATA_MSB:DATA_LSB];
			end
			if (upd[i]) begin
				// The new code and the wake happen together.
				chan_next[i].dacCode = chan_next[i].inputCode;
				chan_next[i].driveOn = 1'b1;
				chan_next[i].pullOn  = 1'b0;
				if (chan_reg[i].powerDown) begin
					chan_next[i].powerDown = 1'b0;
					chan_next[i].settled   = 1'b0;
					wake_next[i] = !bothDown ? WAKE_W'(WAKE_ONE_CYC) :
						(supply5v ? WAKE_W'(WAKE_BIAS5_CYC) : WAKE_W'(WAKE_BIAS3_CYCLES));
				end
			end else if (pdn[i]) begin
				// Codes are left alone; repeating the command changes nothing.
				chan_next[i].powerDown = 1'b1;
				chan_next[i].driveOn   = 1'b0;
				chan_next[i].pullOn    = 1'b1;
				chan_next[i].settled   = 1'b0;
				wake_next[i] = '0;
			end
		end
		bias_next = ~(chan_next[0].powerDown & chan_next[1].powerDown);
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			syncA_reg   <= SYNC_IDLE;
			syncB_reg   <= SYNC_IDLE;
			sckPrev_reg <= 1'b0;
			frame_reg   <= FR_IDLE;
			shift_reg   <= '0;
			cnt_reg     <= '0;
			bias_reg    <= 1'b1;
			for (int i = 0; i < 2; i++) begin
				chan_reg[i] <= '{CODE_RESET, CODE_RESET, 1'b0, 1'b1, 1'b0, 1'b1};
				wake_reg[i] <= '0;
			end
		end else begin
			syncA_reg   <= syncA_next;
			syncB_reg   <= syncB_next;
			sckPrev_reg <= sckPrev_next;
			frame_reg   <= frame_next;
			shift_reg   <= shift_next;
			cnt_reg     <= cnt_next;
			bias_reg    <= bias_next;
			chan_reg    <= chan_next;
			for (int i = 0; i < 2; i++) begin
				wake_reg[i] <= wake_next[i];
			end
		end
	end

	assign chanStat = chan_reg;
	assign biasOn   = bias_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence s_pdownA;
		frame_reg == FR_EXEC && cmd == CMD_PDOWN && addrHit(addr, 1'b0);
	endsequence
	sequence s_updA;
		frame_reg == FR_EXEC && upd[0];
	endsequence
	sequence s_execDone;
		frame_reg == FR_EXEC ##1 frame_reg == FR_IDLE;
	endsequence

	property p_pdown;
		s_pdownA |=> chan_reg[0].powerDown && !chan_reg[0].driveOn;
	endproperty
	a_pdown: assert property (p_pdown) else $error("Channel A did not power down.");

	property p_keepCodes;
		frame_reg == FR_EXEC && cmd == CMD_PDOWN |=>
			$stable({chan_reg[0].inputCode, chan_reg[0].dacCode, chan_reg[1].inputCode, chan_reg[1].dacCode});
	endproperty
	a_keepCodes: assert property (p_keepCodes) else $error("Power-down altered a code.");

	property p_hiz;
		chan_reg[1].powerDown |-> !chan_reg[1].driveOn && chan_reg[1].pullOn;
	endproperty
	a_hiz: assert property (p_hiz) else $error("Down channel B is driving.");

	property p_wake;
		s_updA and (cmd == CMD_UPDATE) |=>
			!chan_reg[0].powerDown && chan_reg[0].driveOn && chan_reg[0].dacCode == $past(chan_reg[0].inputCode);
	endproperty
	a_wake: assert property (p_wake) else $error("Update did not wake channel A with its code.");

	property p_wakeOne;
		s_updA and (chan_reg[0].powerDown && !chan_reg[1].powerDown) |=> wake_reg[0] == WAKE_ONE_CYC;
	endproperty
	a_wakeOne: assert property (p_wakeOne) else $error("Single wake delay wrong.");

	property p_wakeBias;
		s_updA and bothDown |=> wake_reg[0] == ($past(supply5v) ? WAKE_BIAS5_CYC : WAKE_BIAS3_CYCLES);
	endproperty
	a_wakeBias: assert property (p_wakeBias) else $error("Bias wake delay wrong.");

	property p_biasOff;
		bothDown |-> !biasOn;
	endproperty
	a_biasOff: assert property (p_biasOff) else $error("Bias on with both channels down.");

	property p_settle;
		wake_reg[0] == WAKE_W'(1) && !(frame_reg == FR_EXEC && (upd[0] || pdn[0])) |=> chan_reg[0].settled;
	endproperty
	a_settle: assert property (p_settle) else $error("Channel A did not settle at count end.");

	property p_hold;
		chan_reg[1].powerDown && !(frame_reg == FR_EXEC && upd[1]) |=> chan_reg[1].powerDown;
	endproperty
	a_hold: assert property (p_hold) else $error("Power flag cleared without update.");

	property p_shift;
		frame_reg == FR_SHIFT && !selHigh && sckRise && cnt_reg < CNT_W'(SHIFT_W) |=>
			cnt_reg == $past(cnt_reg) + CNT_W'(1) && shift_reg[0] == $past(sdiBit);
	endproperty
	a_shift: assert property (p_shift) else $error("Serial bit not taken.");

	property p_load;
		frame_reg == FR_SHIFT && selHigh && cnt_reg >= CNT_W'(FRAME_BITS) |=> s_execDone;
	endproperty
	a_load: assert property (p_load) else $error("Frame end did not execute.");
endmodule

// *** hw/ddc_pkg.sv ***
// Constants, command codes and carrier types of the dual converter power control.
// Assumes a 200 MHz system clock; the wake cycle counts are derived from that period.
package ddc_pkg;
	localparam int CLK_PERIOD_NS = 5;
	localparam int WAKE_ONE_NS   = 5000;
	localparam int WAKE_BIAS5_NS = 12000;
	localparam int WAKE_BIAS3_NS = 30000;
	localparam int WAKE_ONE_CYC   = (WAKE_ONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_BIAS5_CYC = (WAKE_BIAS5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_BIAS3_CYC = (WAKE_BIAS3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_W         = 13;

	localparam int SHIFT_W    = 32;
	localparam int CNT_W      = 6;
	localparam int FRAME_BITS = 24;
	localparam int CMD_MSB    = 23;
	localparam int CMD_LSB    = 20;
	localparam int ADDR_MSB   = 19;
	localparam int ADDR_LSB   = 16;
	localparam int DATA_MSB   = 15;
	localparam int DATA_LSB   = 0;
	localparam int CODE_W     = 16;

	localparam logic [3:0] CMD_WRITE      = 4'h0;
	localparam logic [3:0] CMD_UPDATE     = 4'h1;
	localparam logic [3:0] CMD_WRITE_ALL  = 4'h2;
	localparam logic [3:0] CMD_WRITE_UPD  = 4'h3;
	localparam logic [3:0] CMD_PDOWN      = 4'h4;
	localparam logic [3:0] ADDR_A         = 4'h0;
	localparam logic [3:0] ADDR_B         = 4'h1;
	localparam logic [3:0] ADDR_ALL       = 4'hf;
	localparam logic [15:0] CODE_RESET    = 16'h0000;

	typedef enum logic [1:0] {FR_IDLE, FR_SHIFT, FR_EXEC} ddc_frame_type;

	typedef struct packed {
		logic [CODE_W-1:0] inputCode;
		logic [CODE_W-1:0] dacCode;
		logic              powerDown;
		logic              driveOn;
		logic              pullOn;
		logic              settled;
	} ddc_chan_type;
endpackage

// *** verification/ddc_host_model.sv ***
// Host side of the three-wire link: frames words onto select, serial clock and data.
// Assumes mclk is the bench clock; every pin changes only at its falling edge.
`timescale 1ns/1ps
module ddc_host_model (
	input  wire logic mclk,
	output logic      selectAndLoad,
	output logic      serialClk,
	output logic      serialIn
);
	initial begin
		selectAndLoad = 1'b1;
		serialClk     = 1'b0;
		serialIn      = 1'b0;
	end
	task automatic pause(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// Sends the low nbits of word, most significant first; the clock rests low between frames.
	task automatic send(input logic [31:0] word, input int nbits);
		selectAndLoad = 1'b0;
		for (int i = nbits - 1; i >= 0; i--) begin
			serialIn = word[i];
			pause(8);
			serialClk = 1'b1;
			pause(8);
			serialClk = 1'b0;
		end
		pause(8);
		selectAndLoad = 1'b1;
		serialIn = ~serialIn;
		pause(8);
	endtask
endmodule

// *** verification/ddc_power_ctrl_test.sv ***
// Self-checking bench of the dual converter power control.
// Assumes the host model drives the link; the low-supply bias wake count is shortened by parameter, the 5 V one is not.
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin fails++; \
	$display("unexpected %s: expected %h seen %h", nm, exp, got); end end
module ddc_power_ctrl_test;
	import ddc_pkg::*;
	localparam int BIAS3 = 50;
	logic               mclk;
	logic               reset;
	logic               selectAndLoad;
	logic               serialClk;
	logic               serialIn;
	logic               supplyHigh;
	ddc_chan_type [1:0] chanStat;
	logic               biasOn;
	int                 fails;
	int                 total_checks;

	ddc_host_model ddc_host_model_inst (.mclk(mclk), .selectAndLoad(selectAndLoad), .serialClk(serialClk),
		.serialIn(serialIn));
	ddc_power_ctrl #(.WAKE_BIAS3_CYCLES(BIAS3)) ddc_power_ctrl_inst (.mclk(mclk), .reset(reset),
		.selectAndLoad(selectAndLoad), .serialClk(serialClk), .serialIn(serialIn), .supplyHigh(supplyHigh),
		.chanStat(chanStat), .biasOn(biasOn));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		#300000;
		fails++;
		stop_test();
	end
	//----------------------------------------
	// Shared tasks
	//----------------------------------------
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic send(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
		ddc_host_model_inst.send({8'h00, c, a, d}, 24);
	endtask
	task automatic check_chan(input int ch, input logic pd, input logic [15:0] inC, input logic [15:0] dacC);
		`CHECK("powerDown", pd, chanStat[ch].powerDown)
		`CHECK("driveOn", ~pd, chanStat[ch].driveOn)
		`CHECK("pullOn", pd, chanStat[ch].pullOn)
		`CHECK("inputCode", inC, chanStat[ch].inputCode)
		`CHECK("dacCode", dacC, chanStat[ch].dacCode)
	endtask
	// Counts cycles until the channel settles; the frame tail has already eaten a few of them.
	task automatic wait_settled(input int ch, input int lo, input int hi);
		int n;
		n = 0;
		`CHECK("settledEarly", 1'b0, chanStat[ch].settled)
		while (chanStat[ch].settled !== 1'b1 && n <= hi) begin
			@(negedge mclk);
			n++;
		end
		if (n > hi) begin
			fails++;
			$display("unexpected settled: expected within %0d seen timeout", hi);
			stop_test();
		end
		`CHECK("wakeInRange", 1'b1, n >= lo)
	endtask
	task automatic test_single;
		send(CMD_WRITE_UPD, ADDR_A, 16'h1234);
		send(CMD_WRITE_UPD, ADDR_B, 16'h5678);
		send(CMD_PDOWN, ADDR_A, 16'hffff);
		check_chan(0, 1'b1, 16'h1234, 16'h1234);
		check_chan(1, 1'b0, 16'h5678, 16'h5678);
		`CHECK("biasOn", 1'b1, biasOn)
		send(CMD_PDOWN, ADDR_A, 16'h0000);
		send(CMD_WRITE, ADDR_A, 16'habcd);
		check_chan(0, 1'b1, 16'habcd, 16'h1234);
		send(CMD_UPDATE, ADDR_A, 16'h0000);
		check_chan(0, 1'b0, 16'habcd, 16'habcd);
		wait_settled(0, WAKE_ONE_CYC - 6, WAKE_ONE_CYC - 1);
		$display("test single done");
	endtask
	task automatic test_both(input logic hi, input int cyc);
		supplyHigh = hi;
		send(CMD_PDOWN, ADDR_ALL, 16'h0000);
		`CHECK("bothDown", 2'b11, {chanStat[1].powerDown, chanStat[0].powerDown})
		`CHECK("biasOn", 1'b0, biasOn)
		send(CMD_WRITE_ALL, ADDR_B, 16'h0f0f);
		check_chan(0, 1'b0, 16'habcd, 16'habcd);
		check_chan(1, 1'b0, 16'h0f0f, 16'h0f0f);
		`CHECK("biasOn", 1'b1, biasOn)
		wait_settled(1, cyc - 6, cyc - 1);
		$display("test both done");
	endtask
	task automatic test_refuse;
		ddc_host_model_inst.send({9'h000, CMD_PDOWN, ADDR_A, 15'h0000}, 23);
		check_chan(0, 1'b0, 16'habcd, 16'habcd);
		send(4'h7, ADDR_A, 16'h5555);
		send(CMD_PDOWN, 4'h5, 16'h0000);
		check_chan(0, 1'b0, 16'habcd, 16'habcd);
		ddc_host_model_inst.send({8'ha5, CMD_PDOWN, ADDR_B, 16'h0000}, 32);
		check_chan(1, 1'b1, 16'h0f0f, 16'h0f0f);
		send(CMD_WRITE_UPD, ADDR_B, 16'h4321);
		check_chan(1, 1'b0, 16'h4321, 16'h4321);
		wait_settled(1, WAKE_ONE_CYC - 6, WAKE_ONE_CYC - 1);
		$display("test refuse done");
	endtask
	initial begin
		fails = 0;
		total_checks = 0;
		reset = 1'b1;
		supplyHigh = 1'b1;
		repeat (16) @(negedge mclk);
		reset = 1'b0;
		repeat (4) @(negedge mclk);
		check_chan(0, 1'b0, CODE_RESET, CODE_RESET);
		check_chan(1, 1'b0, CODE_RESET, CODE_RESET);
		`CHECK("biasOn", 1'b1, biasOn)
		test_single();
		test_both(1'b0, BIAS3);
		test_both(1'b1, WAKE_BIAS5_CYC);
		test_refuse();
		stop_test();
	end
endmodule
